/* shared/fdc_consts.vh */
// Constants of the fixed device configuration block
// Assumes inclusion by bare name from design files
`ifndef FDC_CONSTS_VH
`define FDC_CONSTS_VH
// ----------------------------------------
// Configuration byte values
// ----------------------------------------
`define FDC_CB1L 8'h23
`define FDC_CB1H 8'h02
`define FDC_CB2L 8'h02
`define FDC_CB2H 8'h22
`define FDC_CB3H 8'hD3
`define FDC_CB4L 8'h85
`define FDC_CB5L 8'h0E
`define FDC_CB5H 8'hC0
`define FDC_CB6L 8'h0E
`define FDC_CB6H 8'h80
`define FDC_CB7L 8'h0E
`define FDC_CB7H 8'h40
`define FDC_NUM_CB 12
// ----------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------
`define FDC_IDX_CB_FIRST 4'h0
`define FDC_IDX_CB_LAST 4'hB
`define FDC_IDX_RST_CTRL 4'hC
`define FDC_IDX_WDT_CTRL 4'hD
`define FDC_IDX_CLK_CTRL 4'hE
`define FDC_IDX_STATUS 4'hF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FDC_BIT_XINST 6
`define FDC_BIT_RSTPIN 7
`define FDC_BIT_SDOROUTE 1
`define FDC_BIT_T3ROUTE 4
`define FDC_BIT_CCP2ROUTE 0
`define FDC_BIT_PRIMARY_CLOCK_ENABLE 5
`define FDC_BIT_SOFTBOR 0
`define FDC_BIT_SOFTWDT 0
`define FDC_BIT_USEINT 0
// ----------------------------------------
// Clocks and timing
// ----------------------------------------
`define FDC_XTAL_MHZ 16
`define FDC_PLL_MHZ 8'h30
`define FDC_INTOSC_MAX_MHZ 8'h10
`define FDC_CYC_PER_INSN 3'h4
`define FDC_WDT_POST 256
`define FDC_WDT_MS 1048
`define FDC_CLK_MHZ 25
`define FDC_WDT_BITS 26
// ----------------------------------------
// Flash map
// ----------------------------------------
`define FDC_BOOT_BYTES 16'h2000
`define FDC_READABLE_BYTES 16'h0800
`define FDC_FLASH_AW 15
`endif

/* design/fdc_config.v */
// Fixed configuration bytes, routing, clock selection, brown-out, watchdog and boot protection
// Assumes a classic Wishbone master and a flash controller on the guard ports
`timescale 1ns/10ps
`include "fdc_consts.vh"

// Summary of operation
// - Extended instruction set stays off; only the legacy set decodes.
// - Reset-pin enable at 1 makes the reset pin an active-low reset.
// - Serial-output routing at 1 puts serial data output on port B bit 3.
// - Timer-3 clock routing at 1 takes timer 3 clock from port C bit 0.
// - Compare-unit-2 routing at 1 ties compare unit 2 I/O to port C bit 1.
// - Default clock: 16 MHz crystal, PLL to 48 MHz for CPU and peripherals.
// - Each instruction takes at least four system clocks.
// - Primary-clock enable at 0 lets software move to the internal oscillator.
// - On the internal oscillator the CPU clock stays at 16 MHz at most.
// - Brown-out reset on by default; software clears its enable bit to disable.
// - Soft brown-out enable forced to 1 on every power-up.
// - Watchdog off after reset; software sets its enable bit to start it.
// - Watchdog postscaler 1:256, timeout about 1048 ms.
// - All writes into the boot region are blocked.
// - Only the lowest 2 KB of the boot region are readable by table reads.
// - Boot region is the first 8 KB of flash; the rest is application.
// - Configuration bytes are read-only to software.
module fdc_config #(
   parameter WDT_CYCLES = 26200000,
   parameter FLASH_AW = `FDC_FLASH_AW
) (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output wire wb_ack_o,
   input wire external_reset_pin_n_i,
   input wire brownout_detect_i,
   input wire wdt_clear_i,
   input wire [FLASH_AW-1:0] flash_addr_i,
   input wire flash_wr_req_i,
   input wire flash_rd_req_i,
   output wire flash_wr_allow_o,
   output wire flash_rd_allow_o,
   output reg core_reset_o,
   output reg extended_isa_o,
   output reg reset_pin_is_input_o,
   output reg serial_data_output_on_port_b_bit3_o,
   output reg timer3_clock_input_on_port_c_bit0_o,
   output reg compare_unit2_io_on_port_c_bit1_o,
   output reg clk_use_internal_o,
   output reg pll_enable_o,
   output reg usb_clock_ok_o,
   output reg [7:0] cpu_clk_mhz_o,
   output reg [2:0] insn_cycles_o,
   output reg brownout_reset_o,
   output reg watchdog_reset_o
);
   // ----------------------------------------
   // Configuration storage
   // ----------------------------------------
   reg [7:0] cfg_q [0:`FDC_NUM_CB-1];
   reg latched_q;
   reg soft_bor_q;
   reg soft_wdt_q;
   reg use_int_q;
   reg ack_q;
   reg [31:0] wdt_cnt_q;
   reg [31:0] wdt_cnt_d;
   wire [7:0] cfg_rom [0:`FDC_NUM_CB-1];
   integer k;

   function [7:0] fdc_cfg_val;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: fdc_cfg_val = `FDC_CB1L;
            4'h1: fdc_cfg_val = `FDC_CB1H;
            4'h2: fdc_cfg_val = `FDC_CB2L;
            4'h3: fdc_cfg_val = `FDC_CB2H;
            4'h4: fdc_cfg_val = `FDC_CB3H;
            4'h5: fdc_cfg_val = `FDC_CB4L;
            4'h6: fdc_cfg_val = `FDC_CB5L;
            4'h7: fdc_cfg_val = `FDC_CB5H;
            4'h8: fdc_cfg_val = `FDC_CB6L;
            4'h9: fdc_cfg_val = `FDC_CB6H;
            4'hA: fdc_cfg_val = `FDC_CB7L;
            4'hB: fdc_cfg_val = `FDC_CB7H;
            default: fdc_cfg_val = 8'h00;
         endcase
      end
   endfunction

   // Latch config bytes on the first cycle after reset, release core one cycle later
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (k = 0; k < `FDC_NUM_CB; k = k + 1) begin
            cfg_q[k] <= 8'h00;
         end
         latched_q <= 1'b0;
         core_reset_o <= 1'b1;
      end else begin
         if (!latched_q) begin
            for (k = 0; k < `FDC_NUM_CB; k = k + 1) begin
               cfg_q[k] <= fdc_cfg_val(k[3:0]);
            end
         end
         latched_q <= 1'b1;
         core_reset_o <= !latched_q || (!reset_pin_is_input_o && !external_reset_pin_n_i);
      end
   end

   // ----------------------------------------
   // Decoded selections
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         extended_isa_o <= 1'b0;
         reset_pin_is_input_o <= 1'b0;
         serial_data_output_on_port_b_bit3_o <= 1'b0;
         timer3_clock_input_on_port_c_bit0_o <= 1'b0;
         compare_unit2_io_on_port_c_bit1_o <= 1'b0;
         clk_use_internal_o <= 1'b0;
         pll_enable_o <= 1'b1;
         usb_clock_ok_o <= 1'b1;
         cpu_clk_mhz_o <= `FDC_PLL_MHZ;
         insn_cycles_o <= `FDC_CYC_PER_INSN;
      end else begin
         extended_isa_o <= cfg_q[6][`FDC_BIT_XINST];
         reset_pin_is_input_o <= !cfg_q[4][`FDC_BIT_RSTPIN];
         serial_data_output_on_port_b_bit3_o <= cfg_q[4][`FDC_BIT_SDOROUTE];
         timer3_clock_input_on_port_c_bit0_o <= cfg_q[4][`FDC_BIT_T3ROUTE];
         compare_unit2_io_on_port_c_bit1_o <= cfg_q[4][`FDC_BIT_CCP2ROUTE];
         clk_use_internal_o <= use_int_q && !cfg_q[1][`FDC_BIT_PRIMARY_CLOCK_ENABLE];
         pll_enable_o <= !(use_int_q && !cfg_q[1][`FDC_BIT_PRIMARY_CLOCK_ENABLE]);
         usb_clock_ok_o <= !(use_int_q && !cfg_q[1][`FDC_BIT_PRIMARY_CLOCK_ENABLE]);
         cpu_clk_mhz_o <= (use_int_q && !cfg_q[1][`FDC_BIT_PRIMARY_CLOCK_ENABLE]) ? `FDC_INTOSC_MAX_MHZ : `FDC_PLL_MHZ;
         insn_cycles_o <= `FDC_CYC_PER_INSN;
      end
   end

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   wire wb_req = wb_cyc_i && wb_stb_i && !ack_q;
   // Write lands at the edge where the master sees ack high
   wire wb_wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
   assign wb_ack_o = ack_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         wb_dat_o <= 32'h00000000;
         soft_bor_q <= 1'b1;
         soft_wdt_q <= 1'b0;
         use_int_q <= 1'b0;
      end else begin
         ack_q <= wb_req;
         if (wb_wr && wb_adr_i == `FDC_IDX_RST_CTRL) begin
            soft_bor_q <= wb_dat_i[`FDC_BIT_SOFTBOR];
         end
         if (wb_wr && wb_adr_i == `FDC_IDX_WDT_CTRL) begin
            soft_wdt_q <= wb_dat_i[`FDC_BIT_SOFTWDT];
         end
         if (wb_wr && wb_adr_i == `FDC_IDX_CLK_CTRL) begin
            use_int_q <= wb_dat_i[`FDC_BIT_USEINT];
         end
         if (wb_req) begin
            if (wb_adr_i <= `FDC_IDX_CB_LAST) begin
               wb_dat_o <= {24'h000000, cfg_q[wb_adr_i]};
            end else if (wb_adr_i == `FDC_IDX_RST_CTRL) begin
               wb_dat_o <= {31'h00000000, soft_bor_q};
            end else if (wb_adr_i == `FDC_IDX_WDT_CTRL) begin
               wb_dat_o <= {31'h00000000, soft_wdt_q};
            end else if (wb_adr_i == `FDC_IDX_CLK_CTRL) begin
               wb_dat_o <= {31'h00000000, use_int_q};
            end else begin
               wb_dat_o <= {24'h000000, cpu_clk_mhz_o};
            end
         end
      end
   end

   // ----------------------------------------
   // Brown-out and watchdog
   // ----------------------------------------
   always @* begin
      wdt_cnt_d = wdt_cnt_q;
      if (!soft_wdt_q || wdt_clear_i || watchdog_reset_o) begin
         wdt_cnt_d = 32'h00000000;
      end else begin
         wdt_cnt_d = wdt_cnt_q + 32'h00000001;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wdt_cnt_q <= 32'h00000000;
         watchdog_reset_o <= 1'b0;
         brownout_reset_o <= 1'b0;
      end else begin
         wdt_cnt_q <= wdt_cnt_d;
         watchdog_reset_o <= soft_wdt_q && !watchdog_reset_o && (wdt_cnt_q == WDT_CYCLES - 1);
         brownout_reset_o <= soft_bor_q && brownout_detect_i;
      end
   end

   // ----------------------------------------
   // Boot region protection
   // ----------------------------------------
   wire in_boot = ({1'b0, flash_addr_i} < `FDC_BOOT_BYTES);
   wire in_readable = ({1'b0, flash_addr_i} < `FDC_READABLE_BYTES);
   assign flash_wr_allow_o = flash_wr_req_i && !in_boot;
   assign flash_rd_allow_o = flash_rd_req_i && (!in_boot || in_readable);

endmodule // fdc_config

/* test/fdc_config_props.sv */
// Checker for the fixed configuration block
// Assumes binding to fdc_config by implicit name matching
`timescale 1ns/10ps
module fdc_config_props #(
   parameter FLASH_AW = 15
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire external_reset_pin_n_i,
   input wire brownout_detect_i,
   input wire [FLASH_AW-1:0] flash_addr_i,
   input wire flash_wr_req_i,
   input wire flash_rd_req_i,
   input wire flash_wr_allow_o,
   input wire flash_rd_allow_o,
   input wire core_reset_o,
   input wire extended_isa_o,
   input wire reset_pin_is_input_o,
   input wire serial_data_output_on_port_b_bit3_o,
   input wire timer3_clock_input_on_port_c_bit0_o,
   input wire compare_unit2_io_on_port_c_bit1_o,
   input wire clk_use_internal_o,
   input wire pll_enable_o,
   input wire usb_clock_ok_o,
   input wire [7:0] cpu_clk_mhz_o,
   input wire [2:0] insn_cycles_o,
   input wire brownout_reset_o,
   input wire watchdog_reset_o
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_boot_wr_block: assert property (flash_wr_allow_o == (flash_wr_req_i && flash_addr_i >= 'h2000))
      else $error("write guard wrong");
   a_boot_rd_block: assert property (flash_rd_allow_o == (flash_rd_req_i && (flash_addr_i < 'h800 ||
      flash_addr_i >= 'h2000))) else $error("read guard wrong");
   a_legacy_isa: assert property (!core_reset_o |-> !extended_isa_o) else $error("ext isa on");
   a_pin_is_reset: assert property (!core_reset_o |-> !reset_pin_is_input_o) else $error("pin input");
   a_pin_holds_core: assert property (!external_reset_pin_n_i |=> core_reset_o) else $error("pin ignored");
   a_routes_set: assert property (!core_reset_o |-> serial_data_output_on_port_b_bit3_o &&
      timer3_clock_input_on_port_c_bit0_o && compare_unit2_io_on_port_c_bit1_o) else $error("routing");
   a_pll_default: assert property (!clk_use_internal_o |-> pll_enable_o && usb_clock_ok_o &&
      cpu_clk_mhz_o == 8'h30) else $error("pll clock");
   a_intosc_limit: assert property (clk_use_internal_o |-> !pll_enable_o && !usb_clock_ok_o &&
      cpu_clk_mhz_o <= 8'h10) else $error("int osc clock");
   a_insn_four: assert property (!core_reset_o |-> insn_cycles_o >= 3'h4) else $error("insn cycles");
   a_bor_cause: assert property ($rose(brownout_reset_o) |-> $past(brownout_detect_i)) else $error("bor");
   c_bus: cover property (wb_ack_o);
   c_intosc: cover property (clk_use_internal_o);
   c_wdt: cover property (watchdog_reset_o);
   c_bor: cover property (brownout_reset_o);
endmodule // fdc_config_props

/* test/fdc_config_test.sv */
// Self-checking bench for the fixed configuration block
// Assumes fdc_config and its checker are compiled first
`timescale 1ns/10ps
module fdc_config_test;
   reg clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   reg external_reset_pin_n_i = 1'b1, brownout_detect_i = 1'b0, wdt_clear_i = 1'b0;
   reg flash_wr_req_i = 1'b0, flash_rd_req_i = 1'b0;
   reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   reg [31:0] wb_dat_i = 32'h0;
   reg [14:0] flash_addr_i = 15'h0, fa;
   wire [31:0] wb_dat_o;
   wire [7:0] cpu_clk_mhz_o;
   wire [2:0] insn_cycles_o;
   wire wb_ack_o, flash_wr_allow_o, flash_rd_allow_o, core_reset_o, extended_isa_o, reset_pin_is_input_o;
   wire serial_data_output_on_port_b_bit3_o, timer3_clock_input_on_port_c_bit0_o, compare_unit2_io_on_port_c_bit1_o;
   wire clk_use_internal_o, pll_enable_o, usb_clock_ok_o, brownout_reset_o, watchdog_reset_o;
   integer seed = 32'hce3b1ebc, num_errors = 0, n_tests = 0, i, cnt, cyc_cnt = 0;
   reg [32:0] exp_q[$], note;
   reg [7:0] cb [0:11] = '{8'h23, 8'h02, 8'h02, 8'h22, 8'hD3, 8'h85, 8'h0E, 8'hC0, 8'h0E, 8'h80, 8'h0E, 8'h40};
   fdc_config #(.WDT_CYCLES(20)) i_dut (.*);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial forever #20 clk_i = ~clk_i;
   task stop_test;
      begin
         $display("errors %0d compares %0d", num_errors, n_tests);
         if (num_errors == 0 && n_tests > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task bus(input [3:0] a, input w, input [3:0] s, input [31:0] d, input [32:0] e);
      begin
         @(posedge clk_i);
         wb_adr_i <= a;
         wb_we_i <= w;
         wb_sel_i <= s;
         wb_dat_i <= d;
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         exp_q.push_back(e);
         @(posedge clk_i);
         while (wb_ack_o !== 1'b1) @(posedge clk_i);
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [31:0] e);
      bus(a, 1'b0, 4'hF, 32'h0, {1'b1, e});
   endtask
   task wait_n(input integer n);
      begin
         repeat (n) @(posedge clk_i);
         #1;
      end
   endtask
   task count_wdt(input integer n);
      begin
         cnt = 0;
         repeat (n) begin
            @(posedge clk_i);
            #1;
            if (watchdog_reset_o === 1'b1) cnt = cnt + 1;
         end
      end
   endtask
   task do_reset;
      begin
         rst_i <= 1'b1;
         repeat (5) @(posedge clk_i);
         rst_i <= 1'b0;
         wait_n(3);
      end
   endtask
   always @(posedge clk_i) if (wb_ack_o === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[32]) chk(wb_dat_o, note[31:0]);
   end
   always @(posedge clk_i) begin
      cyc_cnt = cyc_cnt + 1;
      if (cyc_cnt == 6000) begin
         num_errors = num_errors + 1;
         stop_test;
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      do_reset;
      chk({extended_isa_o, reset_pin_is_input_o, insn_cycles_o, cpu_clk_mhz_o}, {2'b00, 3'h4, 8'h30});
      chk({serial_data_output_on_port_b_bit3_o, timer3_clock_input_on_port_c_bit0_o,
         compare_unit2_io_on_port_c_bit1_o}, 32'h7);
      for (i = 0; i < 12; i = i + 1) begin
         bus(i, 1'b1, 4'hF, $random(seed), 33'h0);
         rd(i, {24'h0, cb[i]});
      end
      rd(4'hC, 32'h1);
      brownout_detect_i <= 1'b1;
      wait_n(3);
      chk({31'h0, brownout_reset_o}, 32'h1);
      brownout_detect_i <= 1'b0;
      bus(4'hC, 1'b1, 4'h1, 32'h0, 33'h0);
      rd(4'hC, 32'h0);
      brownout_detect_i <= 1'b1;
      wait_n(3);
      chk({31'h0, brownout_reset_o}, 32'h0);
      brownout_detect_i <= 1'b0;
      do_reset;
      rd(4'hC, 32'h1);
      rd(4'hD, 32'h0);
      count_wdt(30);
      chk(cnt, 0);
      bus(4'hD, 1'b1, 4'hE, 32'h1, 33'h0);
      rd(4'hD, 32'h0);
      bus(4'hD, 1'b1, 4'h1, 32'h1, 33'h0);
      count_wdt(23);
      chk(cnt, 1);
      do_reset;
      bus(4'hE, 1'b1, 4'h1, 32'h1, 33'h0);
      wait_n(2);
      chk({clk_use_internal_o, pll_enable_o, usb_clock_ok_o, cpu_clk_mhz_o}, {3'b100, 8'h10});
      rd(4'hF, 32'h10);
      bus(4'hE, 1'b1, 4'h1, 32'h0, 33'h0);
      rd(4'hF, 32'h30);
      for (i = 0; i < 44; i = i + 1) begin
         fa = (i == 0) ? 15'h07FF : (i == 1) ? 15'h0800 : (i == 2) ? 15'h1FFF : (i == 3) ? 15'h2000 : $random(seed);
         @(posedge clk_i);
         flash_addr_i <= fa;
         flash_wr_req_i <= i[0];
         flash_rd_req_i <= 1'b1;
         #1;
         chk({flash_wr_allow_o, flash_rd_allow_o}, {i[0] && fa >= 15'h2000, fa < 15'h0800 || fa >= 15'h2000});
      end
      external_reset_pin_n_i <= 1'b0;
      wait_n(3);
      chk({31'h0, core_reset_o}, 32'h1);
      external_reset_pin_n_i <= 1'b1;
      wait_n(4);
      chk({31'h0, core_reset_o}, 32'h0);
      stop_test;
   end
endmodule // fdc_config_test
bind fdc_config fdc_config_props #(.FLASH_AW(FLASH_AW)) i_props (.*);
